// file: logic/hrch_cmd_handler.sv
// histogram readout command handler with apb register slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module hrch_cmd_handler #(
    parameter logic [31:0] SERIAL_NUMBER = hrch_pkg::SERIAL_DEFAULT
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [hrch_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [hrch_pkg::DATA_W-1:0] i_pwdata,
    output logic      [hrch_pkg::DATA_W-1:0] o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    input  wire logic [hrch_pkg::NUM_CLASS-1:0] i_hist_avail,
    input  wire logic                       i_meas_done,
    output logic                            o_seq_run,
    output logic                            o_paused,
    output logic      [hrch_pkg::NUM_CLASS-1:0] o_hist_class
);
    import hrch_pkg::*;

    hrch_hist_if hist ();

    hrch_hist_gate u_gate (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .hist      (hist.gate)
    );

    // bus decode
    logic       setup_phase;
    logic       wr_fire;
    logic [7:0] idx;
    logic       mapped;
    logic       wr_cmd;

    assign setup_phase = i_psel & ~i_penable;
    assign wr_fire     = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
    assign idx         = {{IDX_SHIFT{1'b0}}, i_paddr[ADDR_W-1:IDX_SHIFT]};
    assign wr_cmd      = wr_fire & (idx == IDX_CMD);

    always_comb begin
        case (idx)
            IDX_PARAM0, IDX_PARAM1, IDX_PARAM2, IDX_PARAM3,
            IDX_CMD, IDX_PREV, IDX_SEQ_STATE, IDX_CONTENTS,
            IDX_SERIAL: mapped = (i_paddr[IDX_SHIFT-1:0] == '0);
            default:    mapped = 1'b0;
        endcase
    end

    // register state
    logic [7:0]     param_byte_zero_reg, param_byte_zero_next;
    logic [7:0]     param_byte_one_reg,  param_byte_one_next;
    logic [7:0]     param_byte_two_reg,  param_byte_two_next;
    logic [7:0]     param_byte_three_reg, param_byte_three_next;
    logic [7:0]     command_reg,  command_next;
    logic [7:0]     prev_reg,     prev_next;
    logic [7:0]     contents_reg, contents_next;
    logic [31:0]    serial_reg,   serial_next;
    logic           armed_reg,    armed_next;
    hrch_state_type state_reg,    state_next;
    logic [5:0]     class_reg,    class_next;
    logic [31:0]    prdata_reg,   prdata_next;
    logic           pready_reg,   pready_next;
    logic           pslverr_reg,  pslverr_next;

    logic [7:0] wbyte;
    assign wbyte = i_pwdata[7:0];

    always_comb begin
        param_byte_zero_next  = param_byte_zero_reg;
        param_byte_one_next   = param_byte_one_reg;
        param_byte_two_next   = param_byte_two_reg;
        param_byte_three_next = param_byte_three_reg;
        command_next          = command_reg;
        prev_next             = prev_reg;
        contents_next         = contents_reg;
        serial_next           = serial_reg;
        armed_next            = armed_reg;
        if (wr_fire) begin
            case (idx)
                IDX_PARAM0: param_byte_zero_next  = wbyte;
                IDX_PARAM1: param_byte_one_next   = wbyte;
                IDX_PARAM2: param_byte_two_next   = wbyte;
                IDX_PARAM3: param_byte_three_next = wbyte;
                IDX_CMD:    command_next          = wbyte;
                default:    command_next          = command_reg;
            endcase
        end
        if (wr_cmd) begin
            prev_next = command_reg;
            if (wbyte == CMD_ARM) begin
                armed_next = 1'b1;
            end
            if (wbyte == CMD_SERIAL) begin
                serial_next   = SERIAL_NUMBER;
                contents_next = CMD_SERIAL;
            end
        end
    end

    // measurement sequencer
    always_comb begin
        state_next = state_reg;
        class_next = class_reg;
        case (state_reg)
            HRCH_IDLE: begin
                if (wr_cmd && wbyte == CMD_MEASURE) begin
                    state_next = HRCH_RUN;
                end
            end
            HRCH_RUN: begin
                if (armed_reg && hist.match) begin
                    state_next = HRCH_PAUSE;
                    class_next = hist.mask & i_hist_avail;
                end else if (i_meas_done) begin
                    state_next = HRCH_IDLE;
                end
            end
            HRCH_PAUSE: begin
                if (wr_cmd && wbyte == CMD_RESUME) begin
                    state_next = HRCH_RUN;
                    class_next = MASK_RESET;
                end
            end
            default: state_next = HRCH_IDLE;
        endcase
    end

    assign hist.arm   = wr_cmd & (wbyte == CMD_ARM);
    assign hist.p1    = param_byte_one_reg;
    assign hist.p3    = param_byte_three_reg;
    assign hist.avail = i_hist_avail;

    // apb answer: one access cycle, data prepared in setup
    always_comb begin
        prdata_next  = WORD_RESET;
        pready_next  = setup_phase;
        pslverr_next = setup_phase & ~mapped;
        if (setup_phase && !i_pwrite) begin
            case (idx)
                IDX_PARAM0:    prdata_next = {24'h000000, param_byte_zero_reg};
                IDX_PARAM1:    prdata_next = {24'h000000, param_byte_one_reg};
                IDX_PARAM2:    prdata_next = {24'h000000, param_byte_two_reg};
                IDX_PARAM3:    prdata_next = {24'h000000, param_byte_three_reg};
                IDX_CMD:       prdata_next = {24'h000000, command_reg};
                IDX_PREV:      prdata_next = {24'h000000, prev_reg};
                IDX_SEQ_STATE: prdata_next = {16'h0000, 2'b00, class_reg,
                                              5'h00, armed_reg, state_reg};
                IDX_CONTENTS:  prdata_next = {24'h000000, contents_reg};
                IDX_SERIAL:    prdata_next = serial_reg;
                default:       prdata_next = WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            param_byte_zero_reg  <= BYTE_RESET;
            param_byte_one_reg   <= BYTE_RESET;
            param_byte_two_reg   <= BYTE_RESET;
            param_byte_three_reg <= BYTE_RESET;
            command_reg          <= BYTE_RESET;
            prev_reg             <= BYTE_RESET;
            contents_reg         <= BYTE_RESET;
            serial_reg           <= WORD_RESET;
            armed_reg            <= 1'b0;
            state_reg            <= HRCH_IDLE;
            class_reg            <= MASK_RESET;
            prdata_reg           <= WORD_RESET;
            pready_reg           <= 1'b0;
            pslverr_reg          <= 1'b0;
        end else begin
            param_byte_zero_reg  <= param_byte_zero_next;
            param_byte_one_reg   <= param_byte_one_next;
            param_byte_two_reg   <= param_byte_two_next;
            param_byte_three_reg <= param_byte_three_next;
            command_reg          <= command_next;
            prev_reg             <= prev_next;
            contents_reg         <= contents_next;
            serial_reg           <= serial_next;
            armed_reg            <= armed_next;
            state_reg            <= state_next;
            class_reg            <= class_next;
            prdata_reg           <= prdata_next;
            pready_reg           <= pready_next;
            pslverr_reg          <= pslverr_next;
        end
    end

    // run and pause flags straight from flops
    logic run_reg, run_next;
    logic paused_reg, paused_next;

    always_comb begin
        run_next    = (state_next == HRCH_RUN);
        paused_next = (state_next == HRCH_PAUSE);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_reg    <= 1'b0;
            paused_reg <= 1'b0;
        end else begin
            run_reg    <= run_next;
            paused_reg <= paused_next;
        end
    end

    assign o_prdata     = prdata_reg;
    assign o_pready     = pready_reg;
    assign o_pslverr    = pslverr_reg;
    assign o_seq_run    = run_reg;
    assign o_paused     = paused_reg;
    assign o_hist_class = class_reg;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    arm_capture_a: assert property (wr_cmd && wbyte == CMD_ARM |=> armed_reg)
        else $error("arm command did not arm readout");
    pause_enter_a: assert property (
        state_reg == HRCH_RUN && armed_reg && hist.match
        |=> state_reg == HRCH_PAUSE && o_paused && !o_seq_run)
        else $error("selected histogram did not pause sequencer");
    pause_hold_a: assert property (
        state_reg == HRCH_PAUSE && !(wr_cmd && wbyte == CMD_RESUME)
        |=> state_reg == HRCH_PAUSE && !o_seq_run)
        else $error("sequencer left pause without resume");
    resume_run_a: assert property (
        state_reg == HRCH_PAUSE && wr_cmd && wbyte == CMD_RESUME
        |=> state_reg == HRCH_RUN && o_seq_run && !o_paused)
        else $error("resume did not restart sequencer");
    mask_cal_a: assert property (
        hist.arm |=> hist.mask[1:0] == {$past(param_byte_three_reg[P3_OPT]),
                                        $past(param_byte_three_reg[P3_ELEC])})
        else $error("calibration select bits wrong");
    mask_meas_a: assert property (
        hist.arm |=> hist.mask[3:2] == {$past(param_byte_three_reg[P3_DIST]),
                                        $past(param_byte_three_reg[P3_PROX])})
        else $error("measurement select bits wrong");
    mask_pileup_a: assert property (
        hist.arm |=> hist.mask[5:4] == {$past(param_byte_one_reg[P1_PU_SUM]),
                                        $past(param_byte_one_reg[P1_PU_DIST])})
        else $error("pileup select bits wrong");
    start_only_a: assert property (
        state_reg == HRCH_IDLE && !(wr_cmd && wbyte == CMD_MEASURE)
        |=> state_reg == HRCH_IDLE)
        else $error("measurement started without start command");
    serial_load_a: assert property (
        wr_cmd && wbyte == CMD_SERIAL
        |=> contents_reg == CMD_SERIAL && serial_reg == SERIAL_NUMBER)
        else $error("serial readout not loaded");
    apb_ready_a: assert property (setup_phase |=> o_pready ##1 !o_pready)
        else $error("apb ready timing wrong");

    apb_error_a: assert property (
        setup_phase && !mapped
        |=> o_pready && o_pslverr && o_prdata == WORD_RESET)
        else $error("unmapped access not refused");
    err_no_write_a: assert property (
        i_psel && i_penable && o_pslverr
        |=> $stable(command_reg) && $stable(armed_reg))
        else $error("refused write changed a register");
    prev_track_a: assert property (
        wr_cmd |=> prev_reg == $past(command_reg))
        else $error("previous command not kept");
    measure_start_a: assert property (
        state_reg == HRCH_IDLE && wr_cmd && wbyte == CMD_MEASURE
        |=> state_reg == HRCH_RUN && o_seq_run)
        else $error("measure command did not start sequencer");
    pause_class_a: assert property (
        state_reg == HRCH_RUN && armed_reg && hist.match
        |=> o_hist_class != MASK_RESET && (o_hist_class & ~$past(i_hist_avail)) == MASK_RESET)
        else $error("pause class not captured");
    resume_clear_a: assert property (
        state_reg == HRCH_PAUSE && wr_cmd && wbyte == CMD_RESUME
        |=> o_hist_class == MASK_RESET)
        else $error("pause class not cleared on resume");
    run_excl_a: assert property (!(o_seq_run && o_paused))
        else $error("run and pause flags together");
    idle_quiet_a: assert property (
        state_reg == HRCH_IDLE |-> !o_paused && o_hist_class == MASK_RESET)
        else $error("idle sequencer shows pause");

    // main scenarios
    arm_seen_c:    cover property (hist.arm);
    pause_seen_c:  cover property (state_reg == HRCH_RUN ##1 state_reg == HRCH_PAUSE);
    resume_seen_c: cover property (state_reg == HRCH_PAUSE ##1 state_reg == HRCH_RUN);
    serial_seen_c: cover property (wr_cmd && wbyte == CMD_SERIAL);
    measure_end_c: cover property (state_reg == HRCH_RUN && i_meas_done);
endmodule : hrch_cmd_handler

// file: logic/hrch_hist_gate.sv
// histogram selection mask and pause match
`timescale 1ns/1ps
module hrch_hist_gate (
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    hrch_hist_if.gate   hist
);
    import hrch_pkg::*;

    logic [5:0] mask_reg;
    logic [5:0] mask_next;

    always_comb begin
        mask_next = mask_reg;
        if (hist.arm) begin
            mask_next = {hist.p1[P1_PU_SUM], hist.p1[P1_PU_DIST],
                         hist.p3[P3_DIST], hist.p3[P3_PROX],
                         hist.p3[P3_OPT], hist.p3[P3_ELEC]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mask_reg <= MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign hist.mask  = mask_reg;
    assign hist.match = |(mask_reg & hist.avail);
endmodule : hrch_hist_gate

// file: logic/hrch_hist_if.sv
// carrier between command handler and histogram selection gate
`timescale 1ns/1ps
interface hrch_hist_if;
    logic       arm;
    logic [7:0] p1;
    logic [7:0] p3;
    logic [5:0] avail;
    logic [5:0] mask;
    logic       match;
    modport ctrl (output arm, p1, p3, avail, input mask, match);
    modport gate (input arm, p1, p3, avail, output mask, match);
endinterface : hrch_hist_if

// file: logic/hrch_pkg.sv
// constants, register map and state type for the histogram readout command handler
package hrch_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam int          NUM_CLASS        = 6;
    localparam int          IDX_SHIFT        = 2;
    localparam logic [7:0]  IDX_PARAM0       = 8'h0c;
    localparam logic [7:0]  IDX_PARAM1       = 8'h0d;
    localparam logic [7:0]  IDX_PARAM2       = 8'h0e;
    localparam logic [7:0]  IDX_PARAM3       = 8'h0f;
    localparam logic [7:0]  IDX_CMD          = 8'h10;
    localparam logic [7:0]  IDX_PREV         = 8'h11;
    localparam logic [7:0]  IDX_SEQ_STATE    = 8'h1d;
    localparam logic [7:0]  IDX_CONTENTS     = 8'h1e;
    localparam logic [7:0]  IDX_SERIAL       = 8'h20;
    localparam logic [7:0]  CMD_MEASURE      = 8'h04;
    localparam logic [7:0]  CMD_ARM          = 8'h30;
    localparam logic [7:0]  CMD_RESUME       = 8'h32;
    localparam logic [7:0]  CMD_SERIAL       = 8'h47;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
    localparam logic [5:0]  MASK_RESET       = 6'h00;
    localparam logic [31:0] SERIAL_DEFAULT   = 32'h1234_5678;
    localparam int          P3_ELEC          = 1;
    localparam int          P3_OPT           = 2;
    localparam int          P3_PROX          = 4;
    localparam int          P3_DIST          = 7;
    localparam int          P1_PU_DIST       = 0;
    localparam int          P1_PU_SUM        = 1;
    typedef enum logic [1:0] {
        HRCH_IDLE  = 2'b00,
        HRCH_RUN   = 2'b01,
        HRCH_PAUSE = 2'b10
    } hrch_state_type;
endpackage : hrch_pkg

// file: testbench/hrch_meas_model.sv
// measurement engine model facing the command handler sequencer outputs
`timescale 1ns/1ps
module hrch_meas_model (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_seq_run,
    input  wire logic       i_paused,
    input  wire logic [5:0] i_class_sel,
    output logic      [5:0] o_hist_avail,
    output logic            o_meas_done
);
    logic [3:0] step_reg;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            step_reg     <= 4'h0;
            o_hist_avail <= 6'h00;
            o_meas_done  <= 1'b0;
        end else begin
            o_meas_done <= 1'b0;
            if (i_seq_run) begin
                step_reg     <= step_reg + 4'h1;
                o_hist_avail <= (step_reg == 4'h3) ? i_class_sel : 6'h00;
                if (step_reg == 4'h8) begin
                    o_meas_done <= 1'b1;
                    step_reg    <= 4'h0;
                end
            end else begin
                o_hist_avail <= 6'h00;
                if (!i_paused) begin // frozen while paused
                    step_reg <= 4'h0;
                end
            end
        end
    end
endmodule : hrch_meas_model

// file: testbench/test_histogram_readout_command_handler.sv
// self-checking bench for the histogram readout command handler
`timescale 1ns/1ps
module test_histogram_readout_command_handler;
    import hrch_pkg::*;
    localparam logic [31:0] SERIAL_TB = 32'h0bad_cafe; // arbitrary value
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [5:0]  hist_avail;
    logic        meas_done;
    logic        o_seq_run;
    logic        o_paused;
    logic [5:0]  o_hist_class;
    logic [5:0]  class_sel = 6'h00;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;

    hrch_cmd_handler #(.SERIAL_NUMBER(SERIAL_TB)) i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_hist_avail(hist_avail),
        .i_meas_done(meas_done), .o_seq_run(o_seq_run), .o_paused(o_paused),
        .o_hist_class(o_hist_class)
    );
    hrch_meas_model i_model (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_seq_run(o_seq_run), .i_paused(o_paused),
        .i_class_sel(class_sel), .o_hist_avail(hist_avail), .o_meas_done(meas_done)
    );

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
            miscompares++;
        end
    endtask : check

    task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rdata = o_prdata;
        err   = o_pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx << IDX_SHIFT, {24'h0, data}, rd, err);
        check({31'h0, err}, 32'h0, "write error");
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx << IDX_SHIFT, 32'h0, rd, err);
        check({31'h0, err}, 32'h0, "read error");
        check(rd, exp, "read data");
    endtask : rd_chk

    task automatic arm(input logic [7:0] p1, input logic [7:0] p3);
        wr(IDX_PARAM0, 8'h00);
        wr(IDX_PARAM2, 8'h00);
        wr(IDX_PARAM1, p1);
        wr(IDX_PARAM3, p3);
        wr(IDX_CMD, CMD_ARM);
    endtask : arm

    task automatic wait_idle();
        int n;
        n = 0;
        while (o_seq_run !== 1'b0 && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check({30'h0, o_seq_run, o_paused}, 32'h0, "not back to idle");
    endtask : wait_idle

    task automatic test_reset();
        logic [31:0] rd;
        logic        err;
        logic [7:0]  idx [9] = '{IDX_PARAM0, IDX_PARAM1, IDX_PARAM2, IDX_PARAM3, IDX_CMD,
                                IDX_PREV, IDX_SEQ_STATE, IDX_CONTENTS, IDX_SERIAL};
        foreach (idx[k]) rd_chk(idx[k], WORD_RESET);
        apb(1'b0, 8'hc0, 32'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped read accepted");
        apb(1'b1, 8'h41, 32'h04, rd, err);
        check({31'h0, err}, 32'h1, "misaligned write accepted");
        check({30'h0, o_seq_run, o_paused}, 32'h0, "misaligned command acted");
    endtask : test_reset

    task automatic test_arm_only();
        arm(8'h00, 8'h80);
        repeat (20) @(posedge i_clk);
        #1;
        check({31'h0, o_seq_run}, 32'h0, "run without measure command");
        rd_chk(IDX_SEQ_STATE, 32'h4);
        wr(IDX_CMD, CMD_RESUME);
        check({30'h0, o_seq_run, o_paused}, 32'h0, "resume acted in idle");
    endtask : test_arm_only

    task automatic test_class(input int c);
        int          bitpos [6] = '{P3_ELEC, P3_OPT, P3_PROX, P3_DIST, P1_PU_DIST, P1_PU_SUM};
        logic [7:0]  sel;
        int          n;
        sel = 8'h01 << bitpos[c];
        class_sel <= 6'h01 << c;
        arm((c > 3) ? sel : 8'h00, (c > 3) ? 8'h00 : sel);
        wr(IDX_CMD, CMD_MEASURE);
        check({31'h0, o_seq_run}, 32'h1, "measure did not start");
        n = 0;
        while (o_paused !== 1'b1 && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check({26'h0, o_hist_class}, 32'h1 << c, "pause class");
        repeat (20) @(posedge i_clk);
        #1;
        check({30'h0, o_seq_run, o_paused}, 32'h1, "left pause early");
        rd_chk(IDX_SEQ_STATE, (32'h1 << (c + 8)) | 32'h6);
        wr(IDX_CMD, CMD_RESUME);
        check({24'h0, o_hist_class, o_seq_run, o_paused}, 32'h2, "resume");
        wait_idle();
    endtask : test_class

    task automatic test_unselected();
        int seen;
        seen = 0;
        class_sel <= 6'h01;
        arm(8'h02, 8'h80);
        wr(IDX_CMD, CMD_MEASURE);
        repeat (30) begin
            @(posedge i_clk);
            #1;
            if (o_paused === 1'b1) seen++;
        end
        check(seen, 0, "paused on unselected class");
        wait_idle();
    endtask : test_unselected

    task automatic test_mid_reset();
        class_sel <= 6'h08;
        arm(8'h00, 8'h80);
        wr(IDX_CMD, CMD_MEASURE);
        repeat (8) @(posedge i_clk);
        #1;
        check({30'h0, o_seq_run, o_paused}, 32'h1, "not paused before reset");
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        check({24'h0, o_hist_class, o_seq_run, o_paused}, 32'h0, "outputs after reset");
        rd_chk(IDX_SEQ_STATE, WORD_RESET);
        rd_chk(IDX_CMD, WORD_RESET);
        wr(IDX_CMD, CMD_MEASURE);
        wait_idle();
    endtask : test_mid_reset

    task automatic test_serial();
        wr(IDX_CMD, CMD_SERIAL);
        rd_chk(IDX_CONTENTS, {24'h0, CMD_SERIAL});
        rd_chk(IDX_SERIAL, SERIAL_TB);
        rd_chk(IDX_PREV, {24'h0, CMD_MEASURE});
    endtask : test_serial

    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        test_reset();
        test_arm_only();
        for (int c = 0; c < NUM_CLASS; c++) test_class(c);
        test_unselected();
        test_mid_reset();
        test_serial();
        finish_test();
    end
endmodule : test_histogram_readout_command_handler
